// file: hdl/usp_top.sv
/*
   Master SPI mode of a serial unit: data buffer, status, enable, format
   and baud registers on a plain port, a frame engine driving the serial
   clock and data pins, and a two-deep receive buffer.
   Assumes a single-clock register master and pins with an outside pad ring.
*/

// Operation
// - Polarity and phase select four clock modes, sampling leading or trailing edge.
// - Data is set up and sampled on opposite serial clock edges.
// - Frames are exactly eight bits, MSB or LSB first by order select.
// - Receiver and transmitter use the same bit order.
// - After a frame, start the queued one at once or idle output high.
// - Two back-to-back bytes give 16 bits; complete flag after both.
// - Baud divider resets to zero.
// - Transmitter works alone; receiver needs the transmitter for its clock.
// - Enabled transmitter takes over and drives the serial output pin.
// - Enabled receiver takes over the serial input pin; receiver optional.
// - Serial clock pin driven as transfer clock whenever transmitter runs.
// - Writing the data register starts a transfer for send and receive.
// - Written byte moves to the shifter as soon as it is free.
// - On receive overflow the newest byte is dropped, older ones kept.
// - Complete and empty flags as usual; error flags read zero.
// - Mode field value 11 selects master SPI operation.
// - 12-bit divider, bit rate clock/(2(div+1)); low byte reloads now.
`include "usp_defs.svh"

module usp_top
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              serial_in_pin,
   output logic                   serial_out_pin,
   output logic                   serial_out_oe,
   output logic                   serial_clock_pin,
   output logic                   serial_clock_oe,
   output logic                   serial_in_take,
   output logic [1:0]             usart_mode_select
);
   import usp_pkg::*;

   usp_core_t s_reg;
   usp_core_t s_next;
   logic      active;
   logic      sample_edge;
   logic [4:0] set_idx;
   logic [2:0] rx_idx;

   usp_baud_if bif ();

   usp_baud u_baud
   (
      .clock (clock),
      .rst   (rst),
      .bif   (bif)
   );

   // Bit of a frame in transmit order
   function automatic logic frame_bit(input logic [7:0] d, input logic lsb_first, input logic [2:0] idx);
      frame_bit = lsb_first ? d[idx] : d[3'h7 - idx];
   endfunction

   // Register position of a frame bit
   function automatic logic [2:0] bit_pos(input logic lsb_first, input logic [2:0] idx);
      bit_pos = lsb_first ? idx : (`USP_BIT_LAST - idx);
   endfunction

   // Block runs only in master SPI mode with transmitter on
   assign active = s_reg.txen && (s_reg.mode == `USP_MODE_MASTER_SPI_MODE);

   // Sample on leading edges for phase 0, trailing for phase 1
   assign sample_edge = (s_reg.half[0] == s_reg.cpha);
   assign set_idx     = ({1'b0, s_reg.half} + {4'h0, ~s_reg.cpha}) >> 1;
   assign rx_idx      = s_reg.half[3:1];

   // Baud generator control
   assign bif.divider = s_reg.div;
   assign bif.reload  = s_reg.reload;
   assign bif.run     = active;

   // Next-state logic
   always_comb
   begin
      s_next        = s_reg;
      s_next.reload = 1'b0;
      s_next.rdata  = 8'h00;
      s_next.sync1  = serial_in_pin;
      s_next.sync2  = s_reg.sync1;

      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            `USP_OFF_DATA:
            begin
               if (s_reg.txen && !s_reg.txfull)
               begin
                  s_next.txbuf  = reg_wdata;
                  s_next.txfull = 1'b1;
               end
            end
            `USP_OFF_STATUS:
            begin
               if (reg_wdata[`USP_ST_TXC])
               begin
                  s_next.txc = 1'b0;
               end
            end
            `USP_OFF_CTRLB:
            begin
               s_next.rxen = reg_wdata[`USP_CB_RXEN];
               s_next.txen = reg_wdata[`USP_CB_TXEN];
            end
            `USP_OFF_CTRLC:
            begin
               s_next.mode  = reg_wdata[`USP_CC_MODE_HI:`USP_CC_MODE_LO];
               s_next.order = reg_wdata[`USP_CC_ORDER];
               s_next.cpha  = reg_wdata[`USP_CC_PHASE];
               s_next.cpol  = reg_wdata[`USP_CC_POL];
            end
            `USP_OFF_BAUDL:
            begin
               s_next.div[7:0] = reg_wdata;
               s_next.reload   = 1'b1;
            end
            `USP_OFF_BAUDH:
            begin
               s_next.div[11:8] = reg_wdata[3:0];
            end
            default:
            begin
            end
         endcase
      end

      // Register reads, data read pops the receive buffer
      if (reg_rd)
      begin
         case (reg_addr)
            `USP_OFF_DATA:
            begin
               s_next.rdata = s_reg.rx0;
               if (s_reg.rxcnt != 2'd0)
               begin
                  s_next.rx0   = s_reg.rx1;
                  s_next.rxcnt = s_reg.rxcnt - 2'd1;
               end
            end
            `USP_OFF_STATUS:
            begin
               s_next.rdata[`USP_ST_RXC]  = (s_reg.rxcnt != 2'd0);
               s_next.rdata[`USP_ST_TXC]  = s_reg.txc;
               s_next.rdata[`USP_ST_UDRE] = ~s_reg.txfull;
               s_next.rdata[`USP_ST_FE]   = 1'b0;
               s_next.rdata[`USP_ST_DOR]  = 1'b0;
               s_next.rdata[`USP_ST_PE]   = 1'b0;
            end
            `USP_OFF_CTRLB:
            begin
               s_next.rdata[`USP_CB_RXEN] = s_reg.rxen;
               s_next.rdata[`USP_CB_TXEN] = s_reg.txen;
            end
            `USP_OFF_CTRLC:
            begin
               s_next.rdata[`USP_CC_MODE_HI:`USP_CC_MODE_LO] = s_reg.mode;
               s_next.rdata[`USP_CC_ORDER] = s_reg.order;
               s_next.rdata[`USP_CC_PHASE] = s_reg.cpha;
               s_next.rdata[`USP_CC_POL]   = s_reg.cpol;
            end
            `USP_OFF_BAUDL:
            begin
               s_next.rdata = s_reg.div[7:0];
            end
            `USP_OFF_BAUDH:
            begin
               s_next.rdata = {4'h0, s_reg.div[11:8]};
            end
            default:
            begin
               s_next.rdata = 8'h00;
            end
         endcase
      end

      // Frame engine; placed after writes so hardware sets win
      if (!active)
      begin
         s_next.st   = USP_IDLE;
         s_next.half = 4'h0;
         s_next.sck  = s_reg.cpol;
         s_next.txd  = 1'b1;
      end
      else
      begin
         unique case (s_reg.st)
            USP_IDLE:
            begin
               s_next.sck = s_reg.cpol;
               s_next.txd = 1'b1;
               if (s_reg.txfull)
               begin
                  // Load shifter as soon as it is free
                  s_next.st     = USP_SHIFT;
                  s_next.tx_sh  = s_reg.txbuf;
                  s_next.txfull = 1'b0;
                  s_next.half   = 4'h0;
                  s_next.txd    = s_reg.cpha ? 1'b1 : frame_bit(s_reg.txbuf, s_reg.order, 3'h0);
               end
            end
            USP_SHIFT:
            begin
               if (bif.tick)
               begin
                  s_next.sck  = ~s_reg.sck;
                  s_next.half = s_reg.half + 4'h1;
                  if (sample_edge)
                  begin
                     // Capture into the same order as sent
                     s_next.rx_sh[bit_pos(s_reg.order, rx_idx)] = s_reg.sync2;
                  end
                  else if (set_idx[4:3] == 2'b00)
                  begin
                     s_next.txd = frame_bit(s_reg.tx_sh, s_reg.order, set_idx[2:0]);
                  end
                  if (s_reg.half == `USP_HALF_LAST)
                  begin
                     // End of frame: store received byte
                     if (s_reg.rxen)
                     begin
                        if (s_next.rxcnt == 2'd0)
                        begin
                           s_next.rx0   = s_next.rx_sh;
                           s_next.rxcnt = 2'd1;
                        end
                        else if (s_next.rxcnt == 2'd1)
                        begin
                           s_next.rx1   = s_next.rx_sh;
                           s_next.rxcnt = 2'd2;
                        end
                        // Full buffer drops the newest byte
                        else
                        begin
                           s_next.rxcnt = 2'd2;
                        end
                     end
                     if (s_next.txfull)
                     begin
                        // Queued byte follows directly
                        s_next.tx_sh  = s_next.txbuf;
                        s_next.txfull = 1'b0;
                        s_next.half   = 4'h0;
                        s_next.txd    = s_reg.cpha ? 1'b1 : frame_bit(s_next.txbuf, s_reg.order, 3'h0);
                     end
                     else
                     begin
                        s_next.st  = USP_IDLE;
                        s_next.txd = 1'b1;
                        s_next.txc = 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // State register; baud divider resets to zero
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg       <= '0;
         s_reg.st    <= USP_IDLE;
         s_reg.txd   <= 1'b1;
         s_reg.div   <= `USP_RST_BAUD;
         s_reg.mode  <= `USP_RST_MODE;
         s_reg.rdata <= `USP_RST_DATA;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Pin takeover and outputs
   assign reg_rdata         = s_reg.rdata;
   assign serial_out_pin    = s_reg.txd;
   assign serial_out_oe     = s_reg.txen;
   assign serial_clock_pin  = s_reg.sck;
   assign serial_clock_oe   = s_reg.txen;
   assign serial_in_take    = s_reg.rxen;
   assign usart_mode_select = s_reg.mode;

endmodule

// file: inc/usp_defs.svh
/*
   Register offsets, field positions, reset values and mode codes of the
   master SPI serial block. Assumes an 8-bit register port with byte offsets.
*/
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH

// Register offsets
`define USP_OFF_DATA    8'h00
`define USP_OFF_STATUS  8'h04
`define USP_OFF_CTRLB   8'h08
`define USP_OFF_CTRLC   8'h0c
`define USP_OFF_BAUDL   8'h10
`define USP_OFF_BAUDH   8'h14

// Status fields
`define USP_ST_RXC      7
`define USP_ST_TXC      6
`define USP_ST_UDRE     5
`define USP_ST_FE       4
`define USP_ST_DOR      3
`define USP_ST_PE       2

// Enable fields
`define USP_CB_RXEN     4
`define USP_CB_TXEN     3

// Format fields
`define USP_CC_MODE_HI  7
`define USP_CC_MODE_LO  6
`define USP_CC_ORDER    2
`define USP_CC_PHASE    1
`define USP_CC_POL      0

// Mode code and reset values
`define USP_MODE_MASTER_SPI_MODE  2'b11
`define USP_RST_MODE    2'b00
`define USP_RST_BAUD    12'h000
`define USP_RST_DATA    8'h00

// Frame shape
`define USP_HALF_LAST   4'hf
`define USP_BIT_LAST    3'h7

`endif

// file: inc/usp_pkg.sv
/*
   Types of the master SPI serial block: controller state and the state of
   the baud generator. Assumes the constants header is included by users.
*/
package usp_pkg;

   typedef enum logic {USP_IDLE, USP_SHIFT} usp_state_t;

   typedef struct packed {
      usp_state_t  st;
      logic [3:0]  half;
      logic        sck;
      logic        txd;
      logic [7:0]  tx_sh;
      logic [7:0]  rx_sh;
      logic [7:0]  txbuf;
      logic        txfull;
      logic [7:0]  rx0;
      logic [7:0]  rx1;
      logic [1:0]  rxcnt;
      logic        txc;
      logic        txen;
      logic        rxen;
      logic [1:0]  mode;
      logic        order;
      logic        cpha;
      logic        cpol;
      logic [11:0] div;
      logic        reload;
      logic        sync1;
      logic        sync2;
      logic [7:0]  rdata;
   } usp_core_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic        tick;
   } usp_baud_st_t;

endpackage

// file: inc/usp_baud_if.sv
/*
   Link between the controller and its baud generator: divider value,
   reload request, run level and the half-bit tick. Single clock domain.
*/
interface usp_baud_if;
   logic [11:0] divider;
   logic        reload;
   logic        run;
   logic        tick;

   modport ctrl (output divider, output reload, output run, input tick);
   modport gen  (input divider, input reload, input run, output tick);
endinterface

// file: hdl/usp_baud.sv
/*
   Baud generator: a one-cycle tick every divider+1 clocks, i.e. two ticks
   per bit. Assumes run and reload come from registers on the same clock.
*/
`include "usp_defs.svh"

module usp_baud
(
   input  wire logic clock,
   input  wire logic rst,
   usp_baud_if.gen   bif
);
   import usp_pkg::*;

   usp_baud_st_t s_reg;
   usp_baud_st_t s_next;

   // Down counter, reloaded at once on a low-byte write
   always_comb
   begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (!bif.run || bif.reload)
      begin
         s_next.cnt = bif.divider;
      end
      else if (s_reg.cnt == 12'h000)
      begin
         s_next.tick = 1'b1;
         s_next.cnt  = bif.divider;
      end
      else
      begin
         s_next.cnt = s_reg.cnt - 12'h001;
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign bif.tick = s_reg.tick;

endmodule

// file: sim/usp_top_asserts.sv
/*
   Checker of the master SPI block: pins against register writes.
   Assumes a bind to usp_top; sees only its ports.
*/
`include "usp_defs.svh"

module usp_top_asserts
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              clock,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   input wire logic              serial_in_pin,
   input wire logic              serial_out_pin,
   input wire logic              serial_out_oe,
   input wire logic              serial_clock_pin,
   input wire logic              serial_clock_oe,
   input wire logic              serial_in_take,
   input wire logic [1:0]        usart_mode_select
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        cpol_reg;
   logic        cpha_reg;
   logic [11:0] div_reg;
   logic [12:0] gap_reg;
   wire         wr_c = reg_wr && reg_addr == ADDR_W'(`USP_OFF_CTRLC);
   wire         wr_b = reg_wr && reg_addr == ADDR_W'(`USP_OFF_CTRLB);

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Shadow of format and divider, cycles since the clock pin moved
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cpol_reg <= 1'b0;
         cpha_reg <= 1'b0;
         div_reg  <= `USP_RST_BAUD;
         gap_reg  <= 13'h1fff;
      end
      else
      begin
         if (wr_c)
         begin
            cpol_reg <= reg_wdata[`USP_CC_POL];
            cpha_reg <= reg_wdata[`USP_CC_PHASE];
         end
         if (reg_wr && reg_addr == ADDR_W'(`USP_OFF_BAUDL))
            div_reg[7:0] <= reg_wdata;
         if (reg_wr && reg_addr == ADDR_W'(`USP_OFF_BAUDH))
            div_reg[11:8] <= reg_wdata[3:0];
         gap_reg <= $changed(serial_clock_pin) ? 13'h1 : gap_reg + 13'(gap_reg != 13'h1fff);
      end
   end

   // Sample edge: data holds (a rise to idle may close the frame)
   property p_samp_hold;
      $changed(serial_clock_pin) && ((serial_clock_pin != cpol_reg) ^ cpha_reg)
         |-> $stable(serial_out_pin) || serial_out_pin;
   endproperty
   a_samp_hold: assert property (p_samp_hold) else $error("data moved on sample edge");
   property p_half;
      $changed(serial_clock_pin) |-> gap_reg > 13'(div_reg);
   endproperty
   a_half: assert property (p_half) else $error("half bit shorter than divider");
   property p_err;
      reg_rd && reg_addr == ADDR_W'(`USP_OFF_STATUS) |=> reg_rdata[4:2] == 3'h0;
   endproperty
   a_err: assert property (p_err) else $error("error flag read as one");
   property p_mode;
      wr_c |=> usart_mode_select == $past(reg_wdata[7:6]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode field not taken");
   property p_txen;
      wr_b |=> serial_out_oe == $past(reg_wdata[`USP_CB_TXEN]);
   endproperty
   a_txen: assert property (p_txen) else $error("output pin ownership wrong");
   property p_rxen;
      wr_b |=> serial_in_take == $past(reg_wdata[`USP_CB_RXEN]);
   endproperty
   a_rxen: assert property (p_rxen) else $error("input pin ownership wrong");
   property p_pair;
      serial_clock_oe == serial_out_oe;
   endproperty
   a_pair: assert property (p_pair) else $error("clock pin not driven with data");
   property p_idle;
      !serial_out_oe && !$past(serial_out_oe) |-> serial_out_pin;
   endproperty
   a_idle: assert property (p_idle) else $error("data line not idle high");
   property p_rest;
      !serial_clock_oe && $stable(cpol_reg) |-> serial_clock_pin == cpol_reg;
   endproperty
   a_rest: assert property (p_rest) else $error("clock not at rest level");

   c_edge: cover property ($changed(serial_clock_pin));
   c_mode3: cover property (cpha_reg && cpol_reg && $changed(serial_clock_pin));
   c_pop: cover property (reg_rd && reg_addr == ADDR_W'(`USP_OFF_DATA));
endmodule

bind usp_top usp_top_asserts #(.ADDR_W(ADDR_W)) u_usp_top_asserts (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
   .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_clock_pin(serial_clock_pin),
   .serial_clock_oe(serial_clock_oe), .serial_in_take(serial_in_take),
   .usart_mode_select(usart_mode_select));

// file: sim/usp_slave_model.sv
/*
   Slave on the serial pins: captures data out, answers 8'h5a xor count.
   Assumes the bench gives polarity and phase and resets it when idle.
*/
module usp_slave_model
(
   input  wire logic  clock,
   input  wire logic  rst,
   input  wire logic  sclk,
   input  wire logic  mosi,
   input  wire logic  cpol,
   input  wire logic  cpha,
   output logic       miso,
   output logic [7:0] got,
   output logic [7:0] ngot
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sclk_q = 1'b0;
   logic       bitv = 1'b0;
   logic       mosi_q = 1'b1;
   logic [2:0] nsamp;
   logic [6:0] sh;
   wire  [7:0] cur = 8'h5a ^ ngot;
   wire        edg = sclk != sclk_q;
   wire        samp = edg && ((sclk != cpol) ^ cpha);
   assign miso = bitv;

   // Sample on one edge, set up on the other
   always @(posedge clock)
   begin
      sclk_q <= sclk;
      mosi_q <= mosi; // Data as it stood at the clock edge
      if (rst)
      begin
         nsamp <= 3'h0;
         ngot  <= 8'h00;
         got   <= 8'h00;
         bitv  <= 1'b0;
      end
      else if (samp)
      begin
         sh    <= {sh[5:0], mosi_q};
         nsamp <= nsamp + 3'h1;
         if (nsamp == 3'h7)
         begin
            got  <= {sh, mosi_q};
            ngot <= ngot + 8'h01;
         end
      end
      else if (edg)
         bitv <= cur[3'h7 - nsamp];
      else if (nsamp == 3'h0 && sclk == cpol)
         bitv <= cur[7];
   end
endmodule

// file: sim/usp_top_tb.sv
/*
   Bench of the master SPI block: register tasks, slave model on the pins.
   Assumes design, checker and slave model are compiled first.
*/
`include "usp_defs.svh"

module usp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       m_rst = 1'b0;
   logic       m_cpol = 1'b0;
   logic       m_cpha = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, got, ngot, d;
   logic       miso, sout, sclk;
   logic       sck_oe;
   int         bad_count = 0;
   int         n_tests = 0;

   usp_top #(.ADDR_W(8)) u_usp_top (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(miso), .serial_out_pin(sout),
      .serial_out_oe(), .serial_clock_pin(sclk), .serial_clock_oe(sck_oe), .serial_in_take(),
      .usart_mode_select());
   usp_slave_model u_usp_slave_model (
      .clock(clock), .rst(rst || m_rst), .sclk(sclk), .mosi(sout), .cpol(m_cpol),
      .cpha(m_cpha), .miso(miso), .got(got), .ngot(ngot));

   // 200 MHz clock
   initial
   begin
      forever #2.5 clock = ~clock;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask

   // Poll a status bit, bounded
   task automatic wait_st(input int b);
      logic [7:0] v;
      for (int i = 0; i < 2000; i++)
      begin
         rd(`USP_OFF_STATUS, v);
         if (v[b] === 1'b1)
            return;
      end
      $display("[ERR] t=%0t got %h exp %h", $time, v, 8'h01 << b);
      bad_count++;
      give_verdict();
   endtask

   // Reconfigure while idle, model held in reset meanwhile
   task automatic cfg(input logic [2:0] f);
      m_rst  <= 1'b1;
      m_cpol <= f[0];
      m_cpha <= f[1];
      wr(`USP_OFF_CTRLC, {5'b11000, f});
      wr(`USP_OFF_STATUS, 8'h40);
      m_rst <= 1'b0;
   endtask

   // Bit-reversed byte for LSB-first frames
   function automatic logic [7:0] rev(input logic [7:0] v, input logic o);
      logic [7:0] r;
      r = v;
      if (o)
         r = {<<{v}};
      return r;
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rdchk(`USP_OFF_STATUS, 8'h20);
      rdchk(`USP_OFF_BAUDL, 8'h00);
      rdchk(`USP_OFF_BAUDH, 8'h00);
      rdchk(8'h1c, 8'h00);
      cfg(3'h0);
      wr(`USP_OFF_CTRLB, 8'h18);
      wr(`USP_OFF_BAUDL, 8'h03);
      rdchk(`USP_OFF_BAUDL, 8'h03);
      chk({7'h00, sck_oe}, 8'h01);
      $display("test init done");
      for (int f = 0; f < 8; f++)
      begin
         d = 8'h93 + 8'(f * 17);
         cfg(3'(f));
         wr(`USP_OFF_DATA, d);
         wait_st(`USP_ST_TXC);
         chk(got, rev(d, f[2]));
         rdchk(`USP_OFF_DATA, rev(8'h5a, f[2]));
      end
      $display("test modes done");
      cfg(3'h0);
      wr(`USP_OFF_DATA, 8'hc3);
      wr(`USP_OFF_DATA, 8'h3c);
      wait_st(`USP_ST_TXC);
      chk(ngot, 8'h02);
      chk(got, 8'h3c);
      rdchk(`USP_OFF_DATA, 8'h5a);
      rdchk(`USP_OFF_DATA, 8'h5b);
      $display("test pair done");
      cfg(3'h0);
      for (int i = 0; i < 3; i++)
      begin
         wait_st(`USP_ST_UDRE);
         wr(`USP_OFF_DATA, 8'(i));
      end
      wait_st(`USP_ST_TXC);
      chk(ngot, 8'h03);
      rdchk(`USP_OFF_DATA, 8'h5a);
      rdchk(`USP_OFF_DATA, 8'h5b);
      rdchk(`USP_OFF_STATUS, 8'h60);
      $display("test overflow done");
      wr(`USP_OFF_CTRLB, 8'h08);
      cfg(3'h0);
      wr(`USP_OFF_DATA, 8'ha7);
      wait_st(`USP_ST_TXC);
      chk(got, 8'ha7);
      rdchk(`USP_OFF_STATUS, 8'h60);
      wr(`USP_OFF_CTRLB, 8'h00);
      wr(`USP_OFF_DATA, 8'h55);
      repeat (100) @(posedge clock);
      chk(ngot, 8'h01);
      $display("test transmit only done");
      give_verdict();
   end
endmodule
